// ### logic/dcr_top.sv
// Purpose: configuration variables, factory reset, retention and feedback enables
// Assumes: decoded variable writes and reads arrive as single-cycle strobes
// Notes: store walks all defaults once after power-on, busy meanwhile
`timescale 1ns/1ps
`default_nettype none
module dcr_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // variable access from the track decoder
   input wire logic cv_wr,
   input wire logic cv_rd,
   input wire logic [9:0] cv_idx,
   input wire logic [7:0] cv_wdata,
   output logic cv_busy,
   // power state
   input wire logic power_good,
   // live state from drive and functions
   input wire logic [15:0] func_live,
   input wire logic [7:0] speed_live,
   input wire logic [7:0] speed_cmd,
   input wire logic [13:0] loco_addr,
   // retained state out
   output logic [15:0] func_out,
   output logic [7:0] speed_out,
   output logic speed_hold,
   output logic dir_bit,
   // feedback channel
   input wire logic broadcast_req,
   output logic fb_valid,
   output logic [1:0] fb_kind,
   output logic [13:0] fb_data,
   output logic auto_reg_en
);
   dcr_pkg::dcr_state_t state_q, state_d;
   logic [9:0] wipe_idx_q, wipe_idx_d;
   logic [7:0] feedback_opt_q, basic_cfg_q, retention_q, direction_q;
   logic [15:0] func_keep_q;
   logic [7:0] speed_keep_q;
   logic power_q;
   logic resume_q;
   logic rd_pend_q;
   logic fb_valid_q;
   logic [1:0] fb_kind_q;
   logic [13:0] fb_data_q;
   logic [7:0] mem_rdata;

   // access decode
   wire idle = (state_q == dcr_pkg::DCR_IDLE);
   wire user_wr = cv_wr && idle;
   wire reset_hit = user_wr && (cv_idx == dcr_pkg::IDX_FACTORY_RESET) &&
                    (cv_wdata == dcr_pkg::FACTORY_RESET_KEY);
   wire plain_wr = user_wr && !reset_hit;
   wire wiping = (state_q == dcr_pkg::DCR_INIT) || (state_q == dcr_pkg::DCR_WIPE);
   wire [7:0] wipe_val = dcr_pkg::dcr_default(wipe_idx_q);
   wire mem_we = wiping || plain_wr;
   wire [9:0] mem_widx = wiping ? wipe_idx_q : cv_idx;
   wire [7:0] mem_wdata = wiping ? wipe_val : cv_wdata;
   wire wipe_done = wiping && (wipe_idx_q == dcr_pkg::IDX_LAST);
   wire power_rise = power_good && !power_q;
   wire power_fall = !power_good && power_q;
   wire fb_en = basic_cfg_q[dcr_pkg::BIT_FB_EN];

   // sequencer: power-on default fill and factory reset walk
   always_comb begin
      state_d = state_q;
      wipe_idx_d = wipe_idx_q;
      case (state_q)
         dcr_pkg::DCR_INIT, dcr_pkg::DCR_WIPE: begin
            wipe_idx_d = wipe_idx_q + 10'h001;
            if (wipe_done) begin
               state_d = dcr_pkg::DCR_IDLE;
            end
         end
         dcr_pkg::DCR_IDLE: begin
            if (reset_hit) begin
               state_d = dcr_pkg::DCR_WIPE;
               wipe_idx_d = 10'h000;
            end
         end
         default: begin
            state_d = dcr_pkg::DCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= dcr_pkg::DCR_INIT;
         wipe_idx_q <= 10'h000;
      end else begin
         state_q <= state_d;
         wipe_idx_q <= wipe_idx_d;
      end
   end

   // shadow copies of the steering variables, kept beside the store
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         feedback_opt_q <= dcr_pkg::DEF_FEEDBACK_OPT;
         basic_cfg_q <= dcr_pkg::DEF_BASIC_CFG;
         retention_q <= dcr_pkg::DEF_RETENTION;
         direction_q <= dcr_pkg::DEF_DIRECTION;
      end else if (mem_we) begin
         if (mem_widx == dcr_pkg::IDX_FEEDBACK_OPT) begin
            feedback_opt_q <= mem_wdata;
         end
         if (mem_widx == dcr_pkg::IDX_BASIC_CFG) begin
            basic_cfg_q <= mem_wdata;
         end
         if (mem_widx == dcr_pkg::IDX_RETENTION) begin
            retention_q <= mem_wdata;
         end
         if (mem_widx == dcr_pkg::IDX_DIRECTION) begin
            direction_q <= mem_wdata;
         end
      end
   end

   // variable store
   dcr_cv_mem u_mem (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_en(mem_we),
      .wr_idx(mem_widx),
      .wr_data(mem_wdata),
      .rd_idx(cv_idx),
      .rd_data(mem_rdata)
   );

   // retained state: track live values while powered, freeze at power loss
   // these registers stand for non-volatile cells; a real part backs them up
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         power_q <= 1'b0;
         func_keep_q <= 16'h0000;
         speed_keep_q <= 8'h00;
         resume_q <= 1'b0;
      end else begin
         power_q <= power_good;
         if (power_good && power_q) begin
            func_keep_q <= func_live;
         end
         // freeze the kept speed while resuming, else it drifts with the motor
         if (power_good && power_q && !resume_q) begin
            speed_keep_q <= speed_live;
         end
         if (power_rise) begin
            resume_q <= retention_q[dcr_pkg::BIT_KEEP_SPEED];
         end else if (power_fall) begin
            resume_q <= 1'b0;
         end
      end
   end

   // function restore only while retention on, otherwise start all off
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         func_out <= 16'h0000;
         speed_out <= 8'h00;
      end else begin
         if (power_rise) begin
            func_out <= retention_q[dcr_pkg::BIT_KEEP_FUNC] ? func_keep_q : 16'h0000;
         end else begin
            func_out <= func_live;
         end
         // resumed speed overrides the command, which is ignored meanwhile
         speed_out <= (power_rise && retention_q[dcr_pkg::BIT_KEEP_SPEED]) || resume_q ?
                      speed_keep_q : speed_cmd;
      end
   end

   // feedback: a broadcast outranks a variable report in the same cycle
   // the store reads cv_idx directly, so the index need only stand in the strobe cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_q <= 1'b0;
         fb_valid_q <= 1'b0;
         fb_kind_q <= dcr_pkg::FB_NONE;
         fb_data_q <= 14'h0000;
      end else begin
         rd_pend_q <= cv_rd && idle && fb_en;
         fb_valid_q <= 1'b0;
         fb_kind_q <= dcr_pkg::FB_NONE;
         if (broadcast_req && fb_en) begin
            fb_valid_q <= 1'b1;
            fb_kind_q <= dcr_pkg::FB_ADDRESS;
            fb_data_q <= loco_addr;
         end else if (rd_pend_q && fb_en) begin
            fb_valid_q <= 1'b1;
            fb_kind_q <= dcr_pkg::FB_CV_VALUE;
            fb_data_q <= {6'h00, mem_rdata};
         end
      end
   end

   assign fb_valid = fb_valid_q;
   assign fb_kind = fb_kind_q;
   assign fb_data = fb_data_q;
   assign cv_busy = !idle;
   assign speed_hold = resume_q;
   assign dir_bit = direction_q[dcr_pkg::BIT_DIR];
   assign auto_reg_en = feedback_opt_q[dcr_pkg::BIT_AUTO_REG] && fb_en;
endmodule
`default_nettype wire

// ### pkg/dcr_pkg.sv
// Purpose: constants shared by the configuration-variable retention block
// Assumes: 8-bit variables, 10-bit variable index, single clock
// Notes: factory defaults other than the feedback and auto-registration enables are plain values
package dcr_pkg;
   localparam int unsigned IDX_W = 10;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DEPTH = 1024;
   // variable indices
   localparam logic [9:0] IDX_FACTORY_RESET = 10'h008;
   localparam logic [9:0] IDX_FEEDBACK_OPT = 10'h01C;
   localparam logic [9:0] IDX_BASIC_CFG = 10'h01D;
   localparam logic [9:0] IDX_RETENTION = 10'h07A;
   localparam logic [9:0] IDX_DIRECTION = 10'h07C;
   localparam logic [9:0] IDX_LAST = 10'h3FF;
   // trigger value and field positions
   localparam logic [7:0] FACTORY_RESET_KEY = 8'h08;
   localparam int unsigned BIT_DIR = 0;
   localparam int unsigned BIT_KEEP_FUNC = 0;
   localparam int unsigned BIT_KEEP_SPEED = 1;
   localparam int unsigned BIT_FB_EN = 3;
   localparam int unsigned BIT_AUTO_REG = 7;
   // factory defaults
   localparam logic [7:0] DEF_GENERIC = 8'h00;
   localparam logic [7:0] DEF_FEEDBACK_OPT = 8'h80;
   localparam logic [7:0] DEF_BASIC_CFG = 8'h08;
   localparam logic [7:0] DEF_RETENTION = 8'h00;
   localparam logic [7:0] DEF_DIRECTION = 8'h00;
   localparam logic [7:0] DEF_FACTORY_RESET = 8'h00;
   // feedback message kinds
   localparam logic [1:0] FB_NONE = 2'h0;
   localparam logic [1:0] FB_ADDRESS = 2'h1;
   localparam logic [1:0] FB_CV_VALUE = 2'h2;
   typedef enum logic [1:0] {DCR_INIT, DCR_IDLE, DCR_WIPE} dcr_state_t;

   // factory value of one variable
   function automatic logic [7:0] dcr_default(input logic [9:0] idx);
      case (idx)
         IDX_FEEDBACK_OPT: dcr_default = DEF_FEEDBACK_OPT;
         IDX_BASIC_CFG: dcr_default = DEF_BASIC_CFG;
         IDX_RETENTION: dcr_default = DEF_RETENTION;
         IDX_DIRECTION: dcr_default = DEF_DIRECTION;
         IDX_FACTORY_RESET: dcr_default = DEF_FACTORY_RESET;
         default: dcr_default = DEF_GENERIC;
      endcase
   endfunction
endpackage

// ### logic/dcr_cv_mem.sv
// Purpose: variable store, one write port, one registered read port
// Assumes: contents held by non-volatile backing outside this model
// Notes: no reset on the array, only on the read register
`timescale 1ns/1ps
`default_nettype none
module dcr_cv_mem (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // write port
   input wire logic wr_en,
   input wire logic [9:0] wr_idx,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic [9:0] rd_idx,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:dcr_pkg::DEPTH-1];

   // array write, no reset so it maps onto memory
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // read data from a register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[rd_idx];
      end
   end
endmodule
`default_nettype wire

// ### testbench/dcr_monitor.sv
// Purpose: port checker for the variable block
// Assumes: one clock, rst_n async low
// Notes: feedback enable is seen only through auto_reg_en
`timescale 1ns/1ps
`default_nettype none
module dcr_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // variable access
   input wire logic cv_wr,
   input wire logic cv_rd,
   input wire logic [9:0] cv_idx,
   input wire logic [7:0] cv_wdata,
   input wire logic cv_busy,
   // state and feedback
   input wire logic [13:0] loco_addr,
   input wire logic [7:0] speed_out,
   input wire logic speed_hold,
   input wire logic dir_bit,
   input wire logic broadcast_req,
   input wire logic fb_valid,
   input wire logic [1:0] fb_kind,
   input wire logic [13:0] fb_data,
   input wire logic auto_reg_en
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // writes count only while the walk is idle
   wire logic wr_ok = cv_wr && !cv_busy;
   wire logic key = cv_idx == dcr_pkg::IDX_FACTORY_RESET;
   // a broadcast one cycle on would collide with the report
   sequence s_rd;
      cv_rd && !cv_busy && auto_reg_en && !broadcast_req ##1 !broadcast_req;
   endsequence
   AST_DIR: assert property (wr_ok && cv_idx == dcr_pkg::IDX_DIRECTION |=> dir_bit == $past(cv_wdata[0]))
      else $error("direction bit not taken");
   AST_FRST: assert property (wr_ok && key && cv_wdata == dcr_pkg::FACTORY_RESET_KEY |=> cv_busy [*8])
      else $error("factory reset walk missing");
   AST_NORST: assert property (wr_ok && key && cv_wdata != dcr_pkg::FACTORY_RESET_KEY |=>
      !cv_busy ##1 !cv_busy)
      else $error("reset started by wrong key");
   AST_DEFS: assert property ($fell(cv_busy) |-> auto_reg_en && !dir_bit)
      else $error("defaults wrong after walk");
   AST_FBDIS: assert property (wr_ok && cv_idx == dcr_pkg::IDX_BASIC_CFG && !cv_wdata[3] |=> !auto_reg_en)
      else $error("feedback disable ignored");
   AST_AREG: assert property (wr_ok && cv_idx == dcr_pkg::IDX_FEEDBACK_OPT && !cv_wdata[7] |=> !auto_reg_en)
      else $error("registration disable ignored");
   AST_BCAST: assert property (broadcast_req && auto_reg_en |=> fb_valid && fb_kind == dcr_pkg::FB_ADDRESS)
      else $error("broadcast not answered");
   AST_BDATA: assert property (broadcast_req && auto_reg_en |=> fb_data == $past(loco_addr))
      else $error("broadcast address wrong");
   AST_RDVAL: assert property (s_rd |=> fb_valid && fb_kind == dcr_pkg::FB_CV_VALUE)
      else $error("variable report missing");
   AST_HOLD: assert property (speed_hold && $past(speed_hold) |-> $stable(speed_out))
      else $error("held speed moved");
endmodule
bind dcr_top dcr_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .cv_wr(cv_wr), .cv_rd(cv_rd), .cv_idx(cv_idx),
   .cv_wdata(cv_wdata), .cv_busy(cv_busy), .loco_addr(loco_addr), .speed_out(speed_out),
   .speed_hold(speed_hold), .dir_bit(dir_bit), .broadcast_req(broadcast_req), .fb_valid(fb_valid),
   .fb_kind(fb_kind), .fb_data(fb_data), .auto_reg_en(auto_reg_en));
`default_nettype wire

// ### testbench/dcr_station.sv
// Purpose: command station model issuing variable requests
// Assumes: strobes last one cycle, launched off the falling edge
// Notes: index and data stay put after a request
`timescale 1ns/1ps
`default_nettype none
module dcr_station (
   // clock
   input wire logic mclk,
   // requests toward the block
   output logic cv_wr,
   output logic cv_rd,
   output logic [9:0] cv_idx,
   output logic [7:0] cv_wdata,
   output logic broadcast_req
);
   initial begin
      {cv_wr, cv_rd, broadcast_req, cv_idx, cv_wdata} = '0;
   end
   // one strobe cycle, then a clean edge before the next request
   task automatic send(input logic w, input logic r, input logic b, input logic [9:0] i, input logic [7:0] d);
      @(negedge mclk);
      {cv_wr, cv_rd, broadcast_req, cv_idx, cv_wdata} = {w, r, b, i, d};
      @(negedge mclk);
      {cv_wr, cv_rd, broadcast_req} = 3'h0;
   endtask
endmodule
`default_nettype wire

// ### testbench/dcr_top_tb_top.sv
// Purpose: self-checking bench for the variable block
// Assumes: inputs change on the falling edge
// Notes: walks of 1024 cycles are run at full length
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", n, e, a); end end
module dcr_top_tb_top;
   logic mclk, rst_n, power_good, cv_wr, cv_rd, broadcast_req, cv_busy, speed_hold, dir_bit, fb_valid, auto_reg_en, seen;
   logic [9:0] cv_idx;
   logic [7:0] cv_wdata, speed_live, speed_cmd, speed_out;
   logic [15:0] func_live, func_out;
   logic [13:0] loco_addr, fb_data;
   logic [1:0] fb_kind;
   int mismatches = 0;
   int checked = 0;
   dcr_station u_cs (.mclk(mclk), .cv_wr(cv_wr), .cv_rd(cv_rd), .cv_idx(cv_idx), .cv_wdata(cv_wdata),
      .broadcast_req(broadcast_req));
   dcr_top uut (.mclk(mclk), .rst_n(rst_n), .cv_wr(cv_wr), .cv_rd(cv_rd), .cv_idx(cv_idx), .cv_wdata(cv_wdata),
      .cv_busy(cv_busy), .power_good(power_good), .func_live(func_live), .speed_live(speed_live),
      .speed_cmd(speed_cmd), .loco_addr(loco_addr), .func_out(func_out), .speed_out(speed_out),
      .speed_hold(speed_hold), .dir_bit(dir_bit), .broadcast_req(broadcast_req), .fb_valid(fb_valid),
      .fb_kind(fb_kind), .fb_data(fb_data), .auto_reg_en(auto_reg_en));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // bounded waits for the walk and for a feedback pulse
   task automatic wait_idle();
      for (int i = 0; i < 1100 && cv_busy !== 1'b0; i++) @(negedge mclk);
   endtask
   task automatic get_fb();
      // a broadcast answer already stands when the request task returns
      seen = (fb_valid === 1'b1);
      repeat (4) begin
         @(negedge mclk);
         if (fb_valid === 1'b1) seen = 1'b1;
      end
   endtask
   task automatic t_init();
      wait_idle();
      `CHK("auto_reg_en", 1'b1, auto_reg_en)
      u_cs.send(1'b0, 1'b1, 1'b0, dcr_pkg::IDX_BASIC_CFG, 8'h00);
      get_fb();
      `CHK("report", 1'b1, seen)
      `CHK("fb_data", 14'h0008, fb_data)
      $display("test init done");
   endtask
   task automatic t_cfg();
      u_cs.send(1'b1, 1'b0, 1'b0, dcr_pkg::IDX_DIRECTION, 8'h01);
      `CHK("dir_bit", 1'b1, dir_bit)
      u_cs.send(1'b1, 1'b0, 1'b0, dcr_pkg::IDX_FACTORY_RESET, 8'h07);
      `CHK("cv_busy", 1'b0, cv_busy)
      `CHK("dir_kept", 1'b1, dir_bit)
      loco_addr = 14'h2ABC;
      u_cs.send(1'b0, 1'b0, 1'b1, 10'h000, 8'h00);
      `CHK("fb_kind", dcr_pkg::FB_ADDRESS, fb_kind)
      `CHK("fb_addr", 14'h2ABC, fb_data)
      u_cs.send(1'b1, 1'b0, 1'b0, dcr_pkg::IDX_FEEDBACK_OPT, 8'h00);
      `CHK("auto_reg_off", 1'b0, auto_reg_en)
      u_cs.send(1'b1, 1'b0, 1'b0, dcr_pkg::IDX_BASIC_CFG, 8'h00);
      u_cs.send(1'b0, 1'b0, 1'b1, 10'h000, 8'h00);
      get_fb();
      `CHK("fb_silent", 1'b0, seen)
      $display("test cfg done");
   endtask
   task automatic t_keep();
      u_cs.send(1'b1, 1'b0, 1'b0, dcr_pkg::IDX_RETENTION, 8'h03);
      {func_live, speed_live} = {16'hA5A5, 8'h40};
      repeat (3) @(negedge mclk);
      {power_good, func_live, speed_live} = {1'b0, 16'h0000, 8'h00};
      repeat (3) @(negedge mclk);
      {power_good, speed_cmd} = {1'b1, 8'h77};
      @(negedge mclk);
      `CHK("func_out", 16'hA5A5, func_out)
      repeat (3) @(negedge mclk);
      `CHK("speed_hold", 1'b1, speed_hold)
      `CHK("speed_out", 8'h40, speed_out)
      $display("test keep done");
   endtask
   task automatic t_frst();
      u_cs.send(1'b1, 1'b0, 1'b0, dcr_pkg::IDX_FACTORY_RESET, 8'h08);
      `CHK("busy", 1'b1, cv_busy)
      wait_idle();
      `CHK("dir_def", 1'b0, dir_bit)
      `CHK("auto_def", 1'b1, auto_reg_en)
      $display("test factory done");
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog sized well past two walks plus the short tests
   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      end_sim();
   end
   initial begin
      {rst_n, power_good, func_live, speed_live, speed_cmd, loco_addr} = {1'b0, 1'b1, 16'h0, 8'h0, 8'h10, 14'h0};
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      t_init();
      t_cfg();
      t_keep();
      t_frst();
      end_sim();
   end
endmodule
`default_nettype wire
